// ==== mmd_pkg.sv ====
// constants and types shared by the sensing register device and its host controller
// ==========================================================
// Overview of operation
// R1: magnet detection toggles global event bit 2
// R2: flag bit2 level two, bit1 level one
// R3: flag bit 0 gives magnet pole orientation
// R4: amplitude low byte first, high byte next
// R5: channels zero to two selectable inductive, two arrangements
// R6: two-level detector uses channel two data only
// R7: host sets channel two inductive, both electrodes
// R8: button mode forbids antenna register writes
// R9: two-level detector runs beside other interfaces
// R10: setting register four holds enable and filter
// R11: halt, near, contact thresholds plus hysteresis register
// R12: host keeps near threshold below contact threshold
// R13: magnet setting zero: divider and tuning mode
// R14: host keeps tuning target above tuning base
// R15: global bit 7 follows antenna active level
// R16: global bit 1 toggles per antenna event
// R17: bit 0 button events, bit 3 two-level
// R18: reads never alter flags or values
package mmd_pkg;

	// ==========================================================
	// device register offsets
	localparam logic [7:0] OFF_GLOBAL_EVENTS = 8'h11;
	localparam logic [7:0] OFF_MAGNET_FLAGS = 8'h16;
	localparam logic [7:0] OFF_AMP_LOW = 8'h17;
	localparam logic [7:0] OFF_AMP_HIGH = 8'h18;
	localparam logic [7:0] OFF_CHAN2_MODE = 8'h42;
	localparam logic [7:0] OFF_CHAN2_TARGET = 8'h48;
	localparam logic [7:0] OFF_MAGNET_CONFIG1 = 8'h91;
	localparam logic [7:0] OFF_SWITCH_NEAR = 8'hA1;
	localparam logic [7:0] OFF_SWITCH_CONTACT = 8'hA2;
	localparam logic [7:0] ANTENNA_FIRST = 8'h70;
	localparam logic [7:0] ANTENNA_LAST = 8'h7F;

	// writable settings, one array entry each
	localparam int CFG_COUNT = 15;
	localparam logic [7:0] CFG_OFFSETS [CFG_COUNT] = '{
		8'h3F, 8'h42, 8'h45, 8'h48, 8'h4B, 8'h50, 8'h80, 8'h81,
		8'h82, 8'h83, 8'h90, 8'h91, 8'hA0, 8'hA1, 8'hA2};
	localparam int IDX_INDUCT_SEL = 0;
	localparam int IDX_CHAN2_MODE = 1;
	localparam int IDX_UI_ENABLE = 5;
	localparam int IDX_HYST_CONFIG = 6;
	localparam int IDX_HALT_THR = 7;
	localparam int IDX_NEAR_THR = 8;
	localparam int IDX_CONTACT_THR = 9;
	localparam int IDX_MAGNET_CONFIG0 = 10;
	localparam logic [7:0] REG_RESET = 8'h00;

	// ==========================================================
	// field positions
	localparam int GE_BUTTON_BIT = 0;
	localparam int GE_ANT_EVENT_BIT = 1;
	localparam int GE_MAGNET_BIT = 2;
	localparam int GE_TWO_LEVEL_BIT = 3;
	localparam int GE_ANT_ACTIVE_BIT = 7;
	localparam int MF_POLE_BIT = 0;
	localparam int MF_LEVEL1_BIT = 1;
	localparam int MF_LEVEL2_BIT = 2;
	localparam int UI_ENABLE_BIT = 0;
	localparam int NEAR_HYST_LSB = 0;
	localparam int CONTACT_HYST_LSB = 4;
	localparam int NIBBLE_W = 4;
	localparam int DIVIDER_LSB = 0;
	localparam int TUNING_LSB = 4;
	localparam int TUNING_W = 2;
	localparam int SEL_ENABLE_LSB = 0;
	localparam int SEL_COUPLED_LSB = 3;
	localparam int CHANNELS = 3;
	localparam logic [7:0] CHAN2_INDUCTIVE_SETUP = 8'h32;

	// ==========================================================
	// host software port
	localparam logic [7:0] SW_CMD = 8'h00;
	localparam logic [7:0] SW_RESULT = 8'h04;
	localparam logic [7:0] SW_IRQ_STATUS = 8'h08;
	localparam logic [7:0] SW_IRQ_MASK = 8'h0C;
	localparam logic [7:0] SW_CTRL = 8'h10;
	localparam int CMD_DATA_LSB = 8;
	localparam int CMD_READ_BIT = 16;
	localparam int CMD_SETUP_BIT = 17;
	localparam int RES_BUSY_BIT = 8;
	localparam int RES_REFUSED_BIT = 9;
	localparam int IRQ_DONE_BIT = 0;
	localparam int IRQ_REFUSED_BIT = 1;
	localparam int CTRL_BUTTON_BIT = 0;

	typedef enum logic [1:0] {HOST_IDLE, HOST_WRITE, HOST_READ, HOST_CAPTURE} mmd_host_state_t;

endpackage

// ==== mmd_link_if.sv ====
// register link between the sensing device and its host controller
`timescale 1ns/100ps
`default_nettype none
interface mmd_link_if;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic wr;
	logic rd;
	logic [7:0] rdata;

	// ==========================================================
	// one modport per party
	modport device (input addr, input wdata, input wr, input rd, output rdata);
	modport host (output addr, output wdata, output wr, output rd, input rdata);
endinterface
`default_nettype wire

// ==== mmd_device.sv ====
// sensing device end: result registers, settings and two-level detector
`timescale 1ns/100ps
`default_nettype none
module mmd_device (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic ce_in,
	mmd_link_if.device link,
	input wire logic magnet_event_in,
	input wire logic magnet_level1_out_in,
	input wire logic magnet_level2_out_in,
	input wire logic magnet_pole_in,
	input wire logic [15:0] magnet_amplitude_in,
	input wire logic button_event_flag_in,
	input wire logic single_antenna_active_in,
	input wire logic antenna_event_in,
	input wire logic [15:0] channel_two_data_in,
	input wire logic channel_two_valid_in,
	output logic [2:0] inductive_enable_out,
	output logic [2:0] coupled_coil_out,
	output logic [7:0] channel_two_mode_out,
	output logic [3:0] charge_divider_out,
	output logic [1:0] auto_tuning_mode_out,
	output logic two_level_near_out,
	output logic two_level_contact_out,
	output logic filter_halt_out
);
	import mmd_pkg::*;

	// ==========================================================
	// state
	logic [7:0] cfg_q [CFG_COUNT];
	logic [7:0] cfg_d [CFG_COUNT];
	logic magnet_toggle_q, magnet_toggle_d;
	logic antenna_toggle_q, antenna_toggle_d;
	logic near_q, near_d;
	logic contact_q, contact_d;
	logic halt_q, halt_d;
	logic [7:0] rdata_q, rdata_d;
	logic [7:0] global_v;
	logic [7:0] flags_v;
	logic enabled_v;
	logic [15:0] near_thr_v, contact_thr_v, halt_thr_v;
	logic [15:0] near_rel_v, contact_rel_v;

	// release level lies below the set level by the hysteresis, floored at zero
	function automatic logic [15:0] release_level(input logic [15:0] thr, input logic [3:0] hyst);
		logic [15:0] h;
		h = {12'h000, hyst};
		if (thr > h) begin
			release_level = thr - h;
		end else begin
			release_level = 16'h0000;
		end
	endfunction

	// ==========================================================
	// register file writes; read-only offsets simply ignore writes
	always_comb begin
		for (int i = 0; i < CFG_COUNT; i++) begin
			cfg_d[i] = cfg_q[i];
			if (link.wr && link.addr == CFG_OFFSETS[i]) begin
				cfg_d[i] = link.wdata;
			end
		end
	end

	// ==========================================================
	// event toggles: each detection flips its bit, so a poll sees an odd count but a pair cancels out
	always_comb begin
		magnet_toggle_d = magnet_toggle_q ^ magnet_event_in; // see R1
		antenna_toggle_d = antenna_toggle_q ^ antenna_event_in; // see R16
	end

	// ==========================================================
	// two-level detector on channel two samples only
	always_comb begin
		enabled_v = cfg_q[IDX_UI_ENABLE][UI_ENABLE_BIT]; // see R10
		near_thr_v = {8'h00, cfg_q[IDX_NEAR_THR]};
		contact_thr_v = {8'h00, cfg_q[IDX_CONTACT_THR]};
		halt_thr_v = {8'h00, cfg_q[IDX_HALT_THR]};
		near_rel_v = release_level(near_thr_v,
			cfg_q[IDX_HYST_CONFIG][NEAR_HYST_LSB +: NIBBLE_W]); // see R11
		contact_rel_v = release_level(contact_thr_v,
			cfg_q[IDX_HYST_CONFIG][CONTACT_HYST_LSB +: NIBBLE_W]); // see R11
		near_d = near_q;
		contact_d = contact_q;
		halt_d = halt_q;
		// independent of button and antenna inputs, so both may run alongside
		if (!enabled_v) begin // see R9
			near_d = 1'b0;
			contact_d = 1'b0;
			halt_d = 1'b0;
		end else if (channel_two_valid_in) begin // see R6
			halt_d = channel_two_data_in >= halt_thr_v; // see R11
			if (!near_q && channel_two_data_in >= near_thr_v) begin
				near_d = 1'b1;
			end else if (near_q && channel_two_data_in < near_rel_v) begin
				near_d = 1'b0;
			end
			if (!contact_q && channel_two_data_in >= contact_thr_v) begin
				contact_d = 1'b1;
			end else if (contact_q && channel_two_data_in < contact_rel_v) begin
				contact_d = 1'b0;
			end
		end
	end

	// ==========================================================
	// result images assembled live from state and inputs
	always_comb begin
		global_v = 8'h00;
		global_v[GE_BUTTON_BIT] = button_event_flag_in; // see R17
		global_v[GE_ANT_EVENT_BIT] = antenna_toggle_q; // see R16
		global_v[GE_MAGNET_BIT] = magnet_toggle_q; // see R1
		global_v[GE_TWO_LEVEL_BIT] = near_q | contact_q; // see R17
		global_v[GE_ANT_ACTIVE_BIT] = single_antenna_active_in; // see R15
		flags_v = 8'h00; // upper bits unused, read zero
		flags_v[MF_LEVEL2_BIT] = magnet_level2_out_in; // see R2
		flags_v[MF_LEVEL1_BIT] = magnet_level1_out_in; // see R2
		flags_v[MF_POLE_BIT] = magnet_pole_in; // see R3
	end

	// ==========================================================
	// read mux; a read changes nothing but the data register
	always_comb begin
		rdata_d = rdata_q;
		if (link.rd) begin
			rdata_d = 8'h00;
			if (link.addr == OFF_GLOBAL_EVENTS) begin
				rdata_d = global_v; // see R18
			end else if (link.addr == OFF_MAGNET_FLAGS) begin
				rdata_d = flags_v;
			end else if (link.addr == OFF_AMP_LOW) begin
				rdata_d = magnet_amplitude_in[7:0]; // see R4
			end else if (link.addr == OFF_AMP_HIGH) begin
				rdata_d = magnet_amplitude_in[15:8]; // see R4
			end else begin
				for (int i = 0; i < CFG_COUNT; i++) begin
					if (link.addr == CFG_OFFSETS[i]) begin
						rdata_d = cfg_q[i];
					end
				end
			end
		end
	end

	// ==========================================================
	// registers; clock enable low freezes everything
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			for (int i = 0; i < CFG_COUNT; i++) begin
				cfg_q[i] <= REG_RESET;
			end
			magnet_toggle_q <= 1'b0;
			antenna_toggle_q <= 1'b0;
			near_q <= 1'b0;
			contact_q <= 1'b0;
			halt_q <= 1'b0;
			rdata_q <= REG_RESET;
		end else if (ce_in) begin
			for (int i = 0; i < CFG_COUNT; i++) begin
				cfg_q[i] <= cfg_d[i];
			end
			magnet_toggle_q <= magnet_toggle_d;
			antenna_toggle_q <= antenna_toggle_d;
			near_q <= near_d;
			contact_q <= contact_d;
			halt_q <= halt_d;
			rdata_q <= rdata_d;
		end
	end

	// ==========================================================
	// settings steering the front end
	generate
		for (genvar c = 0; c < CHANNELS; c++) begin : g_chan
			// each of channels zero to two picks inductive sensing and its arrangement
			assign inductive_enable_out[c] = cfg_q[IDX_INDUCT_SEL][SEL_ENABLE_LSB + c]; // see R5
			assign coupled_coil_out[c] = cfg_q[IDX_INDUCT_SEL][SEL_COUPLED_LSB + c]; // see R5
		end
	endgenerate

	// outputs straight from flops
	assign channel_two_mode_out = cfg_q[IDX_CHAN2_MODE];
	assign charge_divider_out = cfg_q[IDX_MAGNET_CONFIG0][DIVIDER_LSB +: NIBBLE_W]; // see R13
	assign auto_tuning_mode_out = cfg_q[IDX_MAGNET_CONFIG0][TUNING_LSB +: TUNING_W]; // see R13
	assign two_level_near_out = near_q;
	assign two_level_contact_out = contact_q;
	assign filter_halt_out = halt_q;
	assign link.rdata = rdata_q;

endmodule // mmd_device
`default_nettype wire

// ==== mmd_host.sv ====
// host controller end: software command port, link master and interrupt
`timescale 1ns/100ps
`default_nettype none
module mmd_host (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic ce_in,
	mmd_link_if.host link,
	input wire logic [7:0] sw_addr_in,
	input wire logic [31:0] sw_wdata_in,
	input wire logic sw_wr_in,
	input wire logic sw_rd_in,
	output logic [31:0] sw_rdata_out,
	output logic irq_out
);
	import mmd_pkg::*;

	// ==========================================================
	// state
	mmd_host_state_t state_q, state_d;
	logic [7:0] addr_q, addr_d;
	logic [7:0] wdata_q, wdata_d;
	logic [7:0] result_q, result_d;
	logic refused_q, refused_d;
	logic [1:0] irq_status_q, irq_status_d;
	logic [1:0] irq_mask_q, irq_mask_d;
	logic button_mode_q, button_mode_d;
	logic [7:0] near_shadow_q, near_shadow_d;
	logic [7:0] contact_shadow_q, contact_shadow_d;
	logic [31:0] sw_rdata_q, sw_rdata_d;
	logic [7:0] c_addr, c_data;
	logic launch, bad, done_ev, refuse_ev;

	// ==========================================================
	// command check: illegal settings are refused rather than sent
	always_comb begin
		c_addr = sw_wdata_in[7:0];
		c_data = sw_wdata_in[CMD_DATA_LSB +: 8];
		if (sw_wdata_in[CMD_SETUP_BIT]) begin
			c_addr = OFF_CHAN2_MODE; // see R7
			c_data = CHAN2_INDUCTIVE_SETUP; // see R7
		end
		launch = sw_wr_in && sw_addr_in == SW_CMD && state_q == HOST_IDLE;
		bad = 1'b0;
		if (!sw_wdata_in[CMD_READ_BIT]) begin
			if (button_mode_q && c_addr >= ANTENNA_FIRST && c_addr <= ANTENNA_LAST) begin
				bad = 1'b1; // see R8
			end else if (c_addr == OFF_SWITCH_NEAR && c_data >= contact_shadow_q) begin
				bad = 1'b1; // see R12
			end else if (c_addr == OFF_SWITCH_CONTACT && c_data <= near_shadow_q) begin
				bad = 1'b1; // see R12
			end else if ((c_addr == OFF_CHAN2_TARGET || c_addr == OFF_MAGNET_CONFIG1)
				&& c_data[7:4] <= c_data[3:0]) begin
				bad = 1'b1; // see R14
			end
		end
	end

	// ==========================================================
	// link sequencer and software registers
	always_comb begin
		state_d = state_q;
		addr_d = addr_q;
		wdata_d = wdata_q;
		result_d = result_q;
		refused_d = refused_q;
		near_shadow_d = near_shadow_q;
		contact_shadow_d = contact_shadow_q;
		button_mode_d = button_mode_q;
		irq_mask_d = irq_mask_q;
		done_ev = 1'b0;
		refuse_ev = 1'b0;
		case (state_q)
			HOST_IDLE: begin
				if (launch && bad) begin
					refused_d = 1'b1;
					refuse_ev = 1'b1;
				end else if (launch) begin
					refused_d = 1'b0;
					addr_d = c_addr;
					wdata_d = c_data;
					state_d = sw_wdata_in[CMD_READ_BIT] ? HOST_READ : HOST_WRITE;
				end
			end
			HOST_WRITE: begin
				if (addr_q == OFF_SWITCH_NEAR) begin
					near_shadow_d = wdata_q;
				end
				if (addr_q == OFF_SWITCH_CONTACT) begin
					contact_shadow_d = wdata_q;
				end
				done_ev = 1'b1;
				state_d = HOST_IDLE;
			end
			HOST_READ: begin
				state_d = HOST_CAPTURE;
			end
			HOST_CAPTURE: begin
				result_d = link.rdata;
				done_ev = 1'b1;
				state_d = HOST_IDLE;
			end
			default: begin
				state_d = HOST_IDLE;
			end
		endcase
		if (sw_wr_in && sw_addr_in == SW_CTRL) begin
			button_mode_d = sw_wdata_in[CTRL_BUTTON_BIT];
		end
		if (sw_wr_in && sw_addr_in == SW_IRQ_MASK) begin
			irq_mask_d = sw_wdata_in[1:0];
		end
		// write one clears, but a new event in the same cycle wins
		irq_status_d = irq_status_q;
		if (sw_wr_in && sw_addr_in == SW_IRQ_STATUS) begin
			irq_status_d = irq_status_q & ~sw_wdata_in[1:0];
		end
		irq_status_d[IRQ_DONE_BIT] = irq_status_d[IRQ_DONE_BIT] | done_ev;
		irq_status_d[IRQ_REFUSED_BIT] = irq_status_d[IRQ_REFUSED_BIT] | refuse_ev;
		sw_rdata_d = 32'h0000_0000;
		if (sw_rd_in) begin
			if (sw_addr_in == SW_RESULT) begin
				sw_rdata_d = {22'h000000, refused_q, state_q != HOST_IDLE, result_q};
			end else if (sw_addr_in == SW_IRQ_STATUS) begin
				sw_rdata_d = {30'h00000000, irq_status_q};
			end else if (sw_addr_in == SW_IRQ_MASK) begin
				sw_rdata_d = {30'h00000000, irq_mask_q};
			end else if (sw_addr_in == SW_CTRL) begin
				sw_rdata_d = {31'h00000000, button_mode_q};
			end
		end
	end

	// ==========================================================
	// registers; clock enable low freezes everything
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_q <= HOST_IDLE;
			addr_q <= REG_RESET;
			wdata_q <= REG_RESET;
			result_q <= REG_RESET;
			refused_q <= 1'b0;
			irq_status_q <= 2'h0;
			irq_mask_q <= 2'h0;
			button_mode_q <= 1'b0;
			near_shadow_q <= REG_RESET;
			contact_shadow_q <= REG_RESET;
			sw_rdata_q <= 32'h0000_0000;
		end else if (ce_in) begin
			state_q <= state_d;
			addr_q <= addr_d;
			wdata_q <= wdata_d;
			result_q <= result_d;
			refused_q <= refused_d;
			irq_status_q <= irq_status_d;
			irq_mask_q <= irq_mask_d;
			button_mode_q <= button_mode_d;
			near_shadow_q <= near_shadow_d;
			contact_shadow_q <= contact_shadow_d;
			sw_rdata_q <= sw_rdata_d;
		end
	end

	// strobes decoded from state, address and data from flops
	assign link.addr = addr_q;
	assign link.wdata = wdata_q;
	assign link.wr = state_q == HOST_WRITE;
	assign link.rd = state_q == HOST_READ;
	assign sw_rdata_out = sw_rdata_q;
	assign irq_out = |(irq_status_q & irq_mask_q);

endmodule // mmd_host
`default_nettype wire

// ==== mmd_props.sv ====
// link checker: register link timing and host ordering guards
`timescale 1ns/100ps
`default_nettype none
module mmd_props (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [7:0] rdata
);
	import mmd_pkg::*;
	logic [7:0] near_q, near_d, contact_q, contact_d, mode_q, mode_d;

	// ==========================================================
	// shadows of what the link last wrote, reset like the device
	always_comb begin
		near_d = near_q;
		contact_d = contact_q;
		mode_d = mode_q;
		if (wr && addr == OFF_SWITCH_NEAR) near_d = wdata;
		if (wr && addr == OFF_SWITCH_CONTACT) contact_d = wdata;
		if (wr && addr == OFF_CHAN2_MODE) mode_d = wdata;
	end

	// registers of the shadows
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			near_q <= 8'h00;
			contact_q <= 8'h00;
			mode_q <= 8'h00;
		end else begin
			near_q <= near_d;
			contact_q <= contact_d;
			mode_q <= mode_d;
		end
	end

	// ==========================================================
	// properties, one clock domain
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);

	flags_unused_a: assert property (rd && addr == OFF_MAGNET_FLAGS |=> rdata[7:3] == 5'h00)
		else $error("flag spare bits set");
	tuning_order_a: assert property (wr && (addr == OFF_CHAN2_TARGET || addr == OFF_MAGNET_CONFIG1)
		|-> wdata[7:4] > wdata[3:0])
		else $error("tuning target not above base");
	near_below_a: assert property (wr && addr == OFF_SWITCH_NEAR |-> wdata < contact_q)
		else $error("near threshold not below contact");
	contact_above_a: assert property (wr && addr == OFF_SWITCH_CONTACT |-> wdata > near_q)
		else $error("contact threshold not above near");
	mode_readback_a: assert property (rd && addr == OFF_CHAN2_MODE |=> rdata == mode_q)
		else $error("mode readback differs");
	switch_readback_a: assert property (rd && addr == OFF_SWITCH_NEAR |=> rdata == near_q)
		else $error("near readback differs");
	rdata_hold_a: assert property (!rd |=> $stable(rdata))
		else $error("read data moved without a read");
	// unmapped places read as zero, antenna range left open
	unmapped_zero_a: assert property (rd && !(addr inside {8'h11, 8'h16, 8'h17, 8'h18, 8'h3F,
		8'h42, 8'h45, 8'h48, 8'h4B, 8'h50, 8'h80, 8'h81, 8'h82, 8'h83, 8'h90, 8'h91, 8'hA0,
		8'hA1, 8'hA2, [8'h70:8'h7F]}) |=> rdata == 8'h00)
		else $error("unmapped read not zero");
endmodule // mmd_props
`default_nettype wire

// ==== mmd_bench.sv ====
// self-checking bench: host controller driving the sensing device
`timescale 1ns/100ps
`default_nettype none
module mmd_bench;
	import mmd_pkg::*;
	logic clk_in, rst_n_in, sw_wr_in, sw_rd_in, irq_out, rd_seen, ce;
	logic [7:0] sw_addr_in;
	logic [31:0] sw_wdata_in, sw_rdata_out, v;
	logic mag_ev, lv1, lv2, pole, btn, ant_act, ant_ev, ch2_valid, near, contact, halt;
	logic [15:0] amp, ch2_data;
	logic [2:0] ind_en, cpl;
	logic [7:0] ch2_mode;
	logic [3:0] div;
	logic [1:0] tun;
	logic [31:0] exp_q[$], mask_q[$];
	int error_cnt, compares, seed, i;
	logic [15:0] td [6] = '{16'h0025, 16'h001F, 16'h001D, 16'h0045, 16'h003D, 16'h003B};
	logic [2:0] te [6] = '{3'b100, 3'b100, 3'b000, 3'b111, 3'b111, 3'b101};

	mmd_link_if link();
	mmd_props i_mmd_props (.clk_in(clk_in), .rst_n_in(rst_n_in), .addr(link.addr),
		.wdata(link.wdata), .wr(link.wr), .rd(link.rd), .rdata(link.rdata));
	mmd_device i_mmd_device (.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce), .link(link),
		.magnet_event_in(mag_ev), .magnet_level1_out_in(lv1), .magnet_level2_out_in(lv2),
		.magnet_pole_in(pole), .magnet_amplitude_in(amp), .button_event_flag_in(btn),
		.single_antenna_active_in(ant_act), .antenna_event_in(ant_ev),
		.channel_two_data_in(ch2_data), .channel_two_valid_in(ch2_valid),
		.inductive_enable_out(ind_en), .coupled_coil_out(cpl), .channel_two_mode_out(ch2_mode),
		.charge_divider_out(div), .auto_tuning_mode_out(tun), .two_level_near_out(near),
		.two_level_contact_out(contact), .filter_halt_out(halt));
	mmd_host i_mmd_host (.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce), .link(link),
		.sw_addr_in(sw_addr_in), .sw_wdata_in(sw_wdata_in), .sw_wr_in(sw_wr_in),
		.sw_rd_in(sw_rd_in), .sw_rdata_out(sw_rdata_out), .irq_out(irq_out));

	// ==========================================================
	// clock and watchdog, far beyond the few hundred cycles used
	initial begin
		clk_in = 1'b0;
		forever #2 clk_in = ~clk_in;
	end
	initial begin
		repeat (20000) @(posedge clk_in);
		error_cnt++;
		tally_and_finish();
	end

	task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cmp_bit(input logic got, input logic exp);
		cmp_word({31'h0, got}, {31'h0, exp});
	endtask
	task automatic tally_and_finish();
		$display("mismatches %0d comparisons %0d", error_cnt, compares);
		if (error_cnt == 0 && compares > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask

	// ==========================================================
	// software port: one-cycle strobes, read notes go to the queue
	task automatic sw_write(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_in);
		sw_addr_in <= a;
		sw_wdata_in <= d;
		sw_wr_in <= 1'b1;
		@(posedge clk_in);
		sw_wr_in <= 1'b0;
	endtask
	task automatic sw_read(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		@(posedge clk_in);
		sw_addr_in <= a;
		sw_rd_in <= 1'b1;
		exp_q.push_back(e & m);
		mask_q.push_back(m);
		@(posedge clk_in);
		sw_rd_in <= 1'b0;
	endtask
	// the wait covers the two cycles a link read keeps the host busy
	task automatic cmd(input logic [7:0] a, input logic [7:0] d, input logic r, input logic s);
		sw_write(SW_CMD, {14'h0000, s, r, d, a});
		repeat (2) @(posedge clk_in);
	endtask
	task automatic dev_read(input logic [7:0] a, input logic [7:0] e);
		cmd(a, 8'h00, 1'b1, 1'b0);
		sw_read(SW_RESULT, {24'h000000, e}, 32'h000001FF);
	endtask
	task automatic feed(input logic [15:0] d);
		@(posedge clk_in);
		ch2_data <= d;
		ch2_valid <= 1'b1;
		@(posedge clk_in);
		ch2_valid <= 1'b0;
		repeat (3) @(posedge clk_in);
	endtask

	// result watcher: read data stands only in the cycle after the strobe
	always @(posedge clk_in) begin
		if (rd_seen && exp_q.size() > 0) begin
			cmp_word(sw_rdata_out & mask_q[0], exp_q[0]);
			void'(exp_q.pop_front());
			void'(mask_q.pop_front());
		end
		rd_seen <= sw_rd_in;
	end

	// ==========================================================
	// main sequence
	initial begin
		{rst_n_in, sw_wr_in, sw_rd_in, mag_ev, lv1, lv2, pole} = 7'h00;
		{btn, ant_act, ant_ev, ch2_valid} = 4'h0;
		ce = 1'b1;
		{sw_addr_in, sw_wdata_in, amp, ch2_data} = 72'h0;
		error_cnt = 0;
		compares = 0;
		seed = 32'h79dd9e59;
		repeat (8) @(posedge clk_in);
		rst_n_in <= 1'b1;
		dev_read(OFF_CHAN2_MODE, REG_RESET);
		for (i = 0; i < 8; i++) begin
			@(posedge clk_in);
			{lv2, lv1, pole} <= i[2:0];
			dev_read(OFF_MAGNET_FLAGS, {5'h00, i[2:0]});
		end
		dev_write_ro: begin
			cmd(OFF_MAGNET_FLAGS, 8'hFF, 1'b0, 1'b0);
			dev_read(OFF_MAGNET_FLAGS, 8'h07);
		end
		for (i = 0; i < 2; i++) begin
			v = $random(seed);
			@(posedge clk_in);
			amp <= v[15:0];
			dev_read(OFF_AMP_LOW, v[7:0]);
			dev_read(OFF_AMP_HIGH, v[15:8]);
		end
		// three magnet cycles and one antenna event, levels raised
		@(posedge clk_in);
		{mag_ev, ant_ev, btn, ant_act} <= 4'hF;
		@(posedge clk_in);
		ant_ev <= 1'b0;
		repeat (2) @(posedge clk_in);
		mag_ev <= 1'b0;
		dev_read(OFF_GLOBAL_EVENTS, 8'h87);
		dev_read(OFF_GLOBAL_EVENTS, 8'h87);
		@(posedge clk_in);
		{mag_ev, ant_ev, btn, ant_act} <= 4'hC;
		@(posedge clk_in);
		{mag_ev, ant_ev} <= 2'b00;
		dev_read(OFF_GLOBAL_EVENTS, 8'h00);
		// clock enable low: a detection pulse then must leave the toggle alone
		@(posedge clk_in);
		ce <= 1'b0;
		mag_ev <= 1'b1;
		@(posedge clk_in);
		ce <= 1'b1;
		mag_ev <= 1'b0;
		dev_read(OFF_GLOBAL_EVENTS, 8'h00);
		for (i = 0; i < 3; i++) begin
			cmd(8'h3F, (8'h01 << i) | (8'h01 << (5 - i)), 1'b0, 1'b0);
			cmp_word({29'h0, ind_en}, {29'h0, 3'b001 << i});
			cmp_word({29'h0, cpl}, {29'h0, 3'b100 >> i});
		end
		cmd(8'h90, 8'h2A, 1'b0, 1'b0);
		cmp_word({26'h0, tun, div}, 32'h0000002A);
		cmd(8'h00, 8'h00, 1'b0, 1'b1);
		cmp_word({24'h0, ch2_mode}, {24'h0, CHAN2_INDUCTIVE_SETUP});
		dev_read(OFF_CHAN2_MODE, CHAN2_INDUCTIVE_SETUP);
		// two-level detector with button mode on beside it
		sw_write(SW_CTRL, 32'h00000001);
		sw_read(SW_CTRL, 32'h00000001, 32'hFFFFFFFF);
		cmd(8'h80, 8'h42, 1'b0, 1'b0);
		cmd(8'h81, 8'h30, 1'b0, 1'b0);
		cmd(8'h82, 8'h20, 1'b0, 1'b0);
		cmd(8'h83, 8'h40, 1'b0, 1'b0);
		cmd(8'h50, 8'h01, 1'b0, 1'b0);
		for (i = 0; i < 6; i++) begin
			feed(td[i]);
			cmp_word({29'h0, near, contact, halt}, {29'h0, te[i]});
			dev_read(OFF_GLOBAL_EVENTS, {4'h0, te[i][2] | te[i][1], 3'h0});
		end
		cmd(8'h50, 8'h00, 1'b0, 1'b0);
		feed(16'h0045);
		cmp_word({29'h0, near, contact, halt}, 32'h0);
		// host refusals, then interrupt masking
		cmd(OFF_SWITCH_CONTACT, 8'h50, 1'b0, 1'b0);
		cmd(OFF_SWITCH_NEAR, 8'h60, 1'b0, 1'b0);
		dev_read(OFF_SWITCH_NEAR, 8'h00);
		cmd(OFF_SWITCH_NEAR, 8'h40, 1'b0, 1'b0);
		dev_read(OFF_SWITCH_NEAR, 8'h40);
		sw_write(SW_IRQ_STATUS, 32'h00000003);
		cmd(OFF_CHAN2_TARGET, 8'h35, 1'b0, 1'b0);
		sw_read(SW_IRQ_STATUS, 32'h00000002, 32'h00000002);
		dev_read(OFF_CHAN2_TARGET, 8'h00);
		cmd(OFF_CHAN2_TARGET, 8'h53, 1'b0, 1'b0);
		dev_read(OFF_CHAN2_TARGET, 8'h53);
		cmd(8'h70, 8'h11, 1'b0, 1'b0);
		// the device never stores this range, so only the refusal flag can show the guard
		sw_read(SW_RESULT, 32'h00000200, 32'h00000200);
		dev_read(8'h70, 8'h00);
		dev_read(8'h20, 8'h00);
		sw_read(8'h1C, 32'h0, 32'hFFFFFFFF);
		sw_write(SW_IRQ_MASK, 32'h00000002);
		@(negedge clk_in);
		cmp_bit(irq_out, 1'b1);
		sw_write(SW_IRQ_STATUS, 32'h00000002);
		@(negedge clk_in);
		cmp_bit(irq_out, 1'b0);
		sw_write(SW_IRQ_MASK, 32'h00000001);
		@(negedge clk_in);
		cmp_bit(irq_out, 1'b1);
		repeat (4) @(posedge clk_in);
		tally_and_finish();
	end
endmodule // mmd_bench
`default_nettype wire
